// file: hw/resp_pkg.sv
// Package: response words, readout buffer layout and status register
// Assumes: shared by the response generator and the readout buffer
package resp_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ROW_BYTES = 12;
  localparam int DROW_BYTES = 24;
  localparam int HALF_ROWS = 4;
  localparam logic [7:0] CNT_W_ZERO = 8'h00;
  localparam logic [4:0] STATUS_ADDR = 5'h15;
  localparam logic [2:0] STATUS_PAGE = 3'h2;
  localparam int STATUS_RDY_BIT = 7;

  typedef struct packed {
    logic [2:0] id;
    logic [4:0] addr;
    logic [7:0] data;
  } word_t;

  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_ABORT = 3'h3;
  localparam logic [2:0] CMD_PAGE = 3'h4;

  localparam word_t IDLE_REPLY = '{3'h0, 5'h00, 8'h00};
  localparam logic [2:0] ID_READ_DONE = 3'h1;
  localparam logic [2:0] ID_WRITE_DONE = 3'h2;
  localparam logic [2:0] ID_PAGE = 3'h4;
  localparam word_t READ_BUSY_REPLY = '{3'h3, 5'h13, 8'h33};
  localparam word_t WRITE_BUSY_REPLY = '{3'h6, 5'h0c, 8'hcc};
  localparam word_t BOOT_PENDING_REPLY = '{3'h7, 5'h0b, 8'hff};
  localparam word_t ABORT_REPLY = '{3'h7, 5'h03, 8'h8e};
  localparam word_t FAULT_REPLY = '{3'h7, 5'h15, 8'hff};
  localparam word_t NOT_READY_REPLY = '{3'h7, 5'h1f, 8'hff};
endpackage

// file: hw/link_shift.sv
// Link-side shifter: collects one 16-bit command per frame, shifts out the reply
// Assumes: SPI mode 0, MSB first, sclk runs only inside frames
`timescale 1ns/10ps
`default_nettype none
module link_shift (
  input wire logic sclk, // Link clock from host
  input wire logic ss_n, // Frame select, active low
  input wire logic mosi, // Host data
  output logic miso, // Reply data
  output logic miso_oe, // High while driving miso
  input wire resp_pkg::word_t reply, // Reply word; bit 15 sent directly, the rest copied at the first fall of the frame
  output resp_pkg::word_t cmd_ff, // Last command captured
  output logic [4:0] cnt_ff, // Bits in the last finished frame
  output logic done_tgl_ff // Toggles at frame end
);
  logic [15:0] sh_ff, nxt_sh;
  logic [4:0] bit_ff, nxt_bit;
  logic [15:0] out_ff, nxt_out;

  always_comb begin
    nxt_sh = {sh_ff[14:0], mosi};
    nxt_bit = (bit_ff == 5'd31) ? bit_ff : bit_ff + 5'd1;
    // First bit leaves straight from the reply; the rest shift from a copy taken at the first fall
    nxt_out = (bit_ff == 5'd1) ? {reply[14:0], 1'b0} : {out_ff[14:0], 1'b0};
  end

  // Select high clears the in-frame count between frames
  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      bit_ff <= 5'd0;
    end else begin
      bit_ff <= nxt_bit;
    end
  end

  always_ff @(posedge sclk) begin
    sh_ff <= nxt_sh;
  end

  always_ff @(negedge sclk) begin
    out_ff <= nxt_out;
  end

  // Command and length are taken when select rises, before the count clears
  always_ff @(posedge ss_n) begin
    cmd_ff <= sh_ff;
    cnt_ff <= bit_ff;
    done_tgl_ff <= ~done_tgl_ff;
  end

  assign miso = (bit_ff == 5'd0) ? reply[15] : out_ff[15];
  assign miso_oe = ~ss_n;
endmodule
`default_nettype wire

// file: hw/resp_buf.sv
// Response generator and double-row readout buffer
// Assumes: register file outside answers reads/writes via reg_* handshake
`timescale 1ns/10ps
`default_nettype none
module resp_buf (
  input wire logic ref_clk, // System clock 200 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic sclk, // SPI clock from host
  input wire logic ss_n, // SPI select, active low
  input wire logic mosi, // SPI data in
  output logic miso, // SPI data out
  output logic miso_oe, // Miso drive enable
  output logic data_rdy, // Readout available pin
  input wire logic boot_busy, // Chip still booting
  input wire logic slave_busy, // Slave interface not ready
  output logic reg_req, // Register access request
  output logic reg_wr, // Access is a write
  output logic [7:0] reg_addr, // Page and address
  output logic [7:0] reg_wdata, // Write data
  input wire logic reg_ack, // Access finished
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic frame_start, // New frame acquired, pulse
  input wire logic single_px, // Single-pixel readout mode
  output logic row_req, // Request next double-row, pulse
  output logic [1:0] row_idx, // Double-row index requested
  input wire logic row_valid, // Row data valid, pulse
  input wire logic [8*resp_pkg::DROW_BYTES-1:0] row_data // Double-row bytes
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_RD, ST_WR} op_t;

  resp_pkg::word_t reply_ff, nxt_reply;
  resp_pkg::word_t cmd_link;
  logic [4:0] cnt_link;
  logic [2:0] tgl_sync_ff;
  logic [2:0] nxt_tgl_sync;
  logic [2:0] page_ff, nxt_page;
  op_t op_ff, nxt_op;
  logic req_ff, nxt_req;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [7:0] bytes_ff, nxt_bytes;
  logic [7:0] rptr_ff, nxt_rptr;
  logic [1:0] row_ff, nxt_row;
  logic rowreq_ff, nxt_rowreq;
  logic wait_ff, nxt_wait;
  logic unsent_ff, nxt_unsent;
  logic frame_begin;
  logic [7:0] mem_ff [resp_pkg::DROW_BYTES];
  logic frame_evt;
  logic [4:0] frame_len;
  logic status_hit;
  logic [7:0] status_val;

  link_shift u_link (
    .sclk(sclk),
    .ss_n(ss_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .reply(reply_ff),
    .cmd_ff(cmd_link),
    .cnt_ff(cnt_link),
    .done_tgl_ff()
  );

  ////////////////////////////////////////////////////////////////////////
  // Select crosses through two flops; its rise marks frame end. Command and
  // length are held until the next frame ends, far longer than this delay
  assign nxt_tgl_sync = {tgl_sync_ff[1:0], ss_n};
  assign frame_evt = tgl_sync_ff[1] && !tgl_sync_ff[2];
  assign frame_begin = tgl_sync_ff[2] && !tgl_sync_ff[1];
  assign frame_len = cnt_link;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // Idle select is high; a zero start would fake a frame end
      tgl_sync_ff <= 3'h7;
    end else begin
      tgl_sync_ff <= nxt_tgl_sync;
    end
  end

  assign status_hit = (cmd_link.addr == resp_pkg::STATUS_ADDR) && (page_ff == resp_pkg::STATUS_PAGE);
  assign status_val = {data_rdy, bytes_ff[6:0]};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_reply = reply_ff;
    nxt_page = page_ff;
    nxt_op = op_ff;
    nxt_req = req_ff && !reg_ack;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_bytes = bytes_ff;
    nxt_rptr = rptr_ff;
    nxt_row = row_ff;
    nxt_rowreq = 1'b0;
    nxt_wait = wait_ff;
    // A completion stays until a frame has begun after it, so a poll shows it
    nxt_unsent = unsent_ff && !frame_begin;
    if (reg_ack && op_ff == ST_RD) begin
      nxt_reply = '{resp_pkg::ID_READ_DONE, addr_ff[4:0], reg_rdata};
      nxt_op = ST_IDLE;
      nxt_unsent = 1'b1;
    end else if (reg_ack && op_ff == ST_WR) begin
      nxt_reply = '{resp_pkg::ID_WRITE_DONE, addr_ff[4:0], wdata_ff};
      nxt_op = ST_IDLE;
      nxt_unsent = 1'b1;
    end
    if (frame_evt) begin
      if (boot_busy) begin
        nxt_reply = resp_pkg::BOOT_PENDING_REPLY;
      end else if (slave_busy) begin
        nxt_reply = resp_pkg::NOT_READY_REPLY;
      end else if (frame_len != 5'(resp_pkg::FRAME_BITS)) begin
        nxt_reply = resp_pkg::FAULT_REPLY;
      end else if (cmd_link.id == resp_pkg::CMD_ABORT) begin
        nxt_op = ST_IDLE;
        nxt_req = 1'b0;
        nxt_reply = resp_pkg::ABORT_REPLY;
        nxt_unsent = 1'b0;
      end else if (unsent_ff || (reg_ack && op_ff != ST_IDLE)) begin
        // Completion landed inside this frame, so the host has not seen it yet
        nxt_unsent = 1'b1;
      end else if (op_ff == ST_RD) begin
        nxt_reply = resp_pkg::READ_BUSY_REPLY;
      end else if (op_ff == ST_WR) begin
        nxt_reply = resp_pkg::WRITE_BUSY_REPLY;
      end else begin
        unique case (cmd_link.id)
          resp_pkg::CMD_READ: begin
            if (status_hit) begin
              nxt_reply = '{resp_pkg::ID_READ_DONE, cmd_link.addr, status_val};
            end else if (cmd_link.addr < 5'(resp_pkg::DROW_BYTES) && page_ff == 3'h0
                         && bytes_ff != resp_pkg::CNT_W_ZERO) begin
              nxt_reply = '{resp_pkg::ID_READ_DONE, cmd_link.addr, mem_ff[rptr_ff[4:0]]};
              nxt_rptr = rptr_ff + 8'h01;
              nxt_bytes = bytes_ff - 8'h01;
            end else begin
              nxt_op = ST_RD;
              nxt_req = 1'b1;
              nxt_addr = {page_ff, cmd_link.addr};
              nxt_reply = resp_pkg::READ_BUSY_REPLY;
            end
          end
          resp_pkg::CMD_WRITE: begin
            nxt_op = ST_WR;
            nxt_req = 1'b1;
            nxt_addr = {page_ff, cmd_link.addr};
            nxt_wdata = cmd_link.data;
            nxt_reply = resp_pkg::WRITE_BUSY_REPLY;
          end
          resp_pkg::CMD_PAGE: begin
            nxt_page = cmd_link.addr[2:0];
            nxt_reply = '{resp_pkg::ID_PAGE, {2'b00, cmd_link.addr[2:0]}, 8'h00};
          end
          default: begin
            nxt_reply = resp_pkg::IDLE_REPLY;
          end
        endcase
      end
    end
    // Refill once the current double-row is drained
    if (frame_start) begin
      nxt_row = 2'h0;
      nxt_rowreq = 1'b1;
      nxt_wait = 1'b1;
    end else if (!wait_ff && bytes_ff == resp_pkg::CNT_W_ZERO && row_ff != 2'(resp_pkg::HALF_ROWS - 1)
                 && rptr_ff != resp_pkg::CNT_W_ZERO && !single_px) begin
      nxt_row = row_ff + 2'h1;
      nxt_rowreq = 1'b1;
      nxt_wait = 1'b1;
    end
    if (row_valid) begin
      nxt_wait = 1'b0;
      nxt_rptr = 8'h00;
      nxt_bytes = single_px ? 8'(resp_pkg::ROW_BYTES) : 8'(resp_pkg::DROW_BYTES);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reply_ff <= resp_pkg::IDLE_REPLY;
      page_ff <= 3'h0;
      op_ff <= ST_IDLE;
      req_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      bytes_ff <= resp_pkg::CNT_W_ZERO;
      rptr_ff <= 8'h00;
      row_ff <= 2'h0;
      rowreq_ff <= 1'b0;
      wait_ff <= 1'b0;
      unsent_ff <= 1'b0;
    end else begin
      reply_ff <= nxt_reply;
      page_ff <= nxt_page;
      op_ff <= nxt_op;
      req_ff <= nxt_req;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      bytes_ff <= nxt_bytes;
      rptr_ff <= nxt_rptr;
      row_ff <= nxt_row;
      rowreq_ff <= nxt_rowreq;
      wait_ff <= nxt_wait;
      unsent_ff <= nxt_unsent;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer storage: top row in the low half, bottom row in the high half
  genvar gi;
  generate
    for (gi = 0; gi < resp_pkg::DROW_BYTES; gi++) begin : g_mem
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          mem_ff[gi] <= 8'h00;
        end else if (row_valid) begin
          mem_ff[gi] <= row_data[8*gi +: 8];
        end
      end
    end
  endgenerate

  assign data_rdy = (bytes_ff != resp_pkg::CNT_W_ZERO);
  assign reg_req = req_ff;
  assign reg_wr = (op_ff == ST_WR);
  assign reg_addr = addr_ff;
  assign reg_wdata = wdata_ff;
  assign row_req = rowreq_ff;
  assign row_idx = row_ff;
endmodule
`default_nettype wire

// file: tb/spi_host.sv
// Host model: SPI master, mode 0, MSB first, 48 ns link clock
// Assumes: device shifts reply on miso while ss_n is low
`timescale 1ns/10ps
`default_nettype none
module spi_host (
  output logic sclk, // Link clock, still between frames
  output logic ss_n, // Frame select, active low
  output logic mosi, // Command bit
  input wire logic miso // Reply bit
);
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // A short n gives the wrong-length frame; gap after ss_n rise exceeds 25 ns
  task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rsp);
    rsp = 16'h0000;
    ss_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = cmd[15-i];
      #24 sclk = 1'b1;
      rsp = {rsp[14:0], miso};
      #24 sclk = 1'b0;
    end
    #24 ss_n = 1'b1;
    mosi = ~mosi;
    #40;
  endtask
endmodule
`default_nettype wire

// file: tb/resp_buf_properties.sv
// Checker: register handshake and double-row refill timing
// Assumes: bound into resp_buf, one clock domain
`timescale 1ns/10ps
`default_nettype none
module resp_buf_properties (
  input wire logic ref_clk, // System clock
  input wire logic nrst, // Async reset
  input wire logic boot_busy, // Booting
  input wire logic slave_busy, // Not ready
  input wire logic reg_req, // Access request
  input wire logic reg_wr, // Write flag
  input wire logic [7:0] reg_addr, // Access address
  input wire logic reg_ack, // Access done
  input wire logic frame_start, // New frame
  input wire logic single_px, // Single pixel mode
  input wire logic row_req, // Row request
  input wire logic [1:0] row_idx, // Row index
  input wire logic row_valid, // Row loaded
  input wire logic data_rdy // Ready pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  property p_req_hold;
    reg_req && !reg_ack |=> reg_req && $stable(reg_addr) && $stable(reg_wr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_end;
    reg_ack |=> !reg_req;
  endproperty
  a_req_end: assert property (p_req_end) else $error("request held after ack");
  property p_busy;
    (boot_busy || slave_busy) && !reg_req |=> !reg_req;
  endproperty
  a_busy: assert property (p_busy) else $error("access started while busy");
  property p_fill;
    row_valid && !single_px |-> ##[1:2] data_rdy;
  endproperty
  a_fill: assert property (p_fill) else $error("ready pin low after load");
  property p_row_pulse;
    row_req |=> !row_req;
  endproperty
  a_row_pulse: assert property (p_row_pulse) else $error("row request not a pulse");
  property p_refill_empty;
    row_req && row_idx != 2'd0 |-> !data_rdy;
  endproperty
  a_refill_empty: assert property (p_refill_empty) else $error("refill while not empty");
  property p_row_step;
    row_req && row_idx != 2'd0 |-> row_idx == $past(row_idx) + 2'd1;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row index skipped");
  property p_start_row0;
    frame_start |-> ##[1:8] (row_req && row_idx == 2'd0);
  endproperty
  a_start_row0: assert property (p_start_row0) else $error("first row not requested");
endmodule
bind resp_buf resp_buf_properties chk (.ref_clk, .nrst, .boot_busy, .slave_busy, .reg_req, .reg_wr,
  .reg_addr, .reg_ack, .frame_start, .single_px, .row_req, .row_idx, .row_valid, .data_rdy);
`default_nettype wire

// file: tb/spi_response_and_readout_buffer_bench.sv
// Bench: reply words, register handshake, double-row readout
// Assumes: spi_host drives the link; register file and row source live here
`timescale 1ns/10ps
`default_nettype none
module spi_response_and_readout_buffer_bench;
  logic ref_clk, nrst, sclk, ss_n, mosi, miso, miso_oe, data_rdy, boot_busy, slave_busy, single_px;
  logic reg_req, reg_wr, reg_ack, frame_start, row_req, row_valid, wr, last_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, last_addr, last_wd, last_rd, d;
  logic [1:0] row_idx;
  logic [8*resp_pkg::DROW_BYTES-1:0] row_data, rq[$];
  logic [15:0] rsp;
  logic [4:0] a;
  resp_pkg::word_t w;
  int err_count, compares, ack_dly, n;
  spi_host host (.sclk, .ss_n, .mosi, .miso);
  resp_buf uut (.ref_clk, .nrst, .sclk, .ss_n, .mosi, .miso, .miso_oe, .data_rdy, .boot_busy,
    .slave_busy, .reg_req, .reg_wr, .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .frame_start,
    .single_px, .row_req, .row_idx, .row_valid, .row_data);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic frame(input resp_pkg::word_t c);
    host.xfer(c, 16, rsp);
  endtask
  // Reply to a command comes out in the following polling frame
  task automatic ask(input resp_pkg::word_t c, input resp_pkg::word_t exp);
    frame(c);
    frame(resp_pkg::IDLE_REPLY);
    check(rsp, exp);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin : regfile
    forever begin
      @(posedge ref_clk);
      if (reg_req === 1'b1) begin
        {last_wr, last_addr, last_wd} = {reg_wr, reg_addr, reg_wdata};
        repeat (ack_dly) @(posedge ref_clk);
        #1 reg_rdata = 8'($urandom);
        last_rd = reg_rdata;
        reg_ack = 1'b1;
        tick();
        reg_ack = 1'b0;
        reg_rdata = ~reg_rdata;
      end
    end
  end
  initial begin : rows
    forever begin
      @(posedge ref_clk);
      if (row_req === 1'b1) begin
        check(row_idx, 24'(rq.size() % resp_pkg::HALF_ROWS));
        repeat (3) @(posedge ref_clk);
        #1 for (int i = 0; i < 6; i++) row_data[32*i +: 32] = $urandom;
        rq.push_back(row_data);
        row_valid = 1'b1;
        tick();
        row_valid = 1'b0;
      end
    end
  end
  initial begin
    #300us;
    err_count++;
    summarize();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(48));
    {nrst, boot_busy, slave_busy, reg_ack, frame_start, row_valid, single_px} = 7'b0100000;
    {reg_rdata, row_data, err_count, compares, ack_dly} = '0;
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (4) tick();
    ask(resp_pkg::IDLE_REPLY, resp_pkg::BOOT_PENDING_REPLY);
    tick();
    {boot_busy, slave_busy} = 2'b01;
    ask({resp_pkg::CMD_READ, 5'h01, 8'h00}, resp_pkg::NOT_READY_REPLY);
    tick();
    slave_busy = 1'b0;
    ask(resp_pkg::IDLE_REPLY, resp_pkg::IDLE_REPLY);
    fork
      host.xfer(16'h0000, 15, rsp);
      begin
        #100;
        check(miso_oe, 1'b1);
      end
    join
    check(miso_oe, 1'b0);
    frame(resp_pkg::IDLE_REPLY);
    check(rsp, resp_pkg::FAULT_REPLY);
    ask({resp_pkg::CMD_ABORT, 13'h0000}, resp_pkg::ABORT_REPLY);
    for (int p = 0; p < 8; p++) ask({resp_pkg::CMD_PAGE, 5'(p), 8'h00}, {resp_pkg::ID_PAGE, 5'(p), 8'h00});
    // Slow acks first so the busy replies show, then quick ones
    for (int k = 0; k < 4; k++) begin
      {a, d, wr} = {5'($urandom), 8'($urandom), k[0]};
      ack_dly = (k < 2) ? 300 : 2;
      frame({wr ? resp_pkg::CMD_WRITE : resp_pkg::CMD_READ, a, wr ? d : 8'h00});
      frame(resp_pkg::IDLE_REPLY);
      if (k < 2) check(rsp, wr ? resp_pkg::WRITE_BUSY_REPLY : resp_pkg::READ_BUSY_REPLY);
      for (n = 0; n < 8 && rsp[15:13] inside {3'h3, 3'h6}; n++) frame(resp_pkg::IDLE_REPLY);
      check(rsp, {wr ? resp_pkg::ID_WRITE_DONE : resp_pkg::ID_READ_DONE, a, wr ? d : last_rd});
      check({last_wr, last_addr, wr ? last_wd : 8'h00}, {wr, 3'h7, a, wr ? d : 8'h00});
    end
    frame({resp_pkg::CMD_PAGE, 5'(resp_pkg::STATUS_PAGE), 8'h00});
    tick();
    frame_start = 1'b1;
    tick();
    frame_start = 1'b0;
    repeat (20) tick();
    check(data_rdy, 1'b1);
    w = {resp_pkg::ID_READ_DONE, resp_pkg::STATUS_ADDR, 1'b1, 7'(resp_pkg::DROW_BYTES)};
    ask({resp_pkg::CMD_READ, resp_pkg::STATUS_ADDR, 8'h00}, w);
    frame({resp_pkg::CMD_PAGE, 13'h0000});
    for (int r = 0; r < resp_pkg::HALF_ROWS; r++) begin
      for (int i = 0; i < resp_pkg::DROW_BYTES; i++) begin
        frame({resp_pkg::CMD_READ, 5'(i), 8'h00});
        if (r + i > 0) check(rsp, w);
        w = {resp_pkg::ID_READ_DONE, 5'(i), rq[r][8*i +: 8]};
      end
    end
    frame({resp_pkg::CMD_PAGE, 5'(resp_pkg::STATUS_PAGE), 8'h00});
    check(rsp, w);
    repeat (20) tick();
    check(data_rdy, 1'b0);
    check(rq.size(), resp_pkg::HALF_ROWS);
    w = {resp_pkg::ID_READ_DONE, resp_pkg::STATUS_ADDR, 8'h00};
    ask({resp_pkg::CMD_READ, resp_pkg::STATUS_ADDR, 8'h00}, w);
    // Single-pixel readout: one row's worth, no advance to another double-row
    tick();
    {single_px, frame_start} = 2'b11;
    tick();
    frame_start = 1'b0;
    repeat (20) tick();
    w = {resp_pkg::ID_READ_DONE, resp_pkg::STATUS_ADDR, 1'b1, 7'(resp_pkg::ROW_BYTES)};
    ask({resp_pkg::CMD_READ, resp_pkg::STATUS_ADDR, 8'h00}, w);
    frame({resp_pkg::CMD_PAGE, 13'h0000});
    for (int i = 0; i < resp_pkg::ROW_BYTES; i++) begin
      frame({resp_pkg::CMD_READ, 5'(i), 8'h00});
      if (i > 0) check(rsp, w);
      w = {resp_pkg::ID_READ_DONE, 5'(i), rq[resp_pkg::HALF_ROWS][8*i +: 8]};
    end
    frame({resp_pkg::CMD_PAGE, 5'(resp_pkg::STATUS_PAGE), 8'h00});
    check(rsp, w);
    repeat (20) tick();
    check(data_rdy, 1'b0);
    check(rq.size(), resp_pkg::HALF_ROWS + 1);
    summarize();
  end
endmodule
`default_nettype wire
